/* pmu_evsel_defs.vh */
// event identifier codes, counter count, field widths and reset values for the event select and mask logic
// assumes a single controller clock; included by every design file of this block
// Operation
// - five counters count their selected enabled event
// - masking only when restrict=1 and security disable=0
// - exactly five counters numbered zero to four
// - remote sgi events 0x15 to 0x18
// - masked sgi events suppressed when nonsecure flag 0
// - translation lpi events 0x20 to 0x23
// - translation cache misses 0x24 to 0x26
// - 0x27 latency, 0x28 free slots amounts
// - remote lpi traffic events 0x29 to 0x2E
// - lpi storage events 0x30, 0x31, unfiltered
// - storage event selection on an enabled counter keeps clock running
// - property hits 0x32 to 0x35 use filter zero
// - 0x36 free slots on new lpi, unfiltered
// - property fetches 0x37 to 0x39 use filter zero
// - collator message and spi enable/disable events
// - spi pending set, clear, collated edge events
// - remote spi traffic events 0x57 to 0x5B
// - masked spi events suppressed for secure groups
// - pending table writes and priority 0x60 to 0x62
`ifndef PMU_EVSEL_DEFS_VH
`define PMU_EVSEL_DEFS_VH

`define NUM_COUNTERS        5
`define EVSEL_W             8
`define AMOUNT_W            8
`define COUNT_W             32
`define SEL_FIELD_LSB       0
`define COUNTER_RESET       32'h0000_0000
`define EVSEL_RESET         8'h00

`define EV_TGT_SGI_RIN      8'h15
`define EV_TGT_SGI_ROUT     8'h16
`define EV_ANY_SGI_ROUT     8'h17
`define EV_SGI_ROUT_RESP    8'h18
`define EV_XLAT_NORMAL      8'h20
`define EV_XLAT_LOWLAT      8'h21
`define EV_XLAT_ANY         8'h22
`define EV_XLAT_CMD         8'h23
`define EV_XLAT_DEVID_MISS  8'h24
`define EV_XLAT_EVID_MISS   8'h25
`define EV_XLAT_COLL_MISS   8'h26
`define EV_XLAT_LATENCY     8'h27
`define EV_XLAT_FREE        8'h28
`define EV_LPI_ROUT         8'h29
`define EV_LPI_CMD_ROUT     8'h2A
`define EV_LPI_RIN          8'h2B
`define EV_LPI_CMD_RIN      8'h2C
`define EV_LPI_ROUT_RESP    8'h2D
`define EV_LPI_CMD_RESP     8'h2E
`define EV_STORED_HOME      8'h30
`define EV_STORED_ELSE      8'h31
`define EV_HIT_EN           8'h32
`define EV_HIT_DIS          8'h33
`define EV_HIT_ANY          8'h34
`define EV_COALESCED        8'h35
`define EV_FREE_NEW         8'h36
`define EV_FETCH_EN         8'h37
`define EV_FETCH_DIS        8'h38
`define EV_FETCH_ANY        8'h39
`define EV_COLL_MSG         8'h50
`define EV_SPI_EN           8'h51
`define EV_SPI_DIS          8'h52
`define EV_SPI_PEND_SET     8'h53
`define EV_SPI_PEND_CLR     8'h54
`define EV_SPI_COLLATED     8'h55
`define EV_SPI_RIN          8'h57
`define EV_SPI_ROUT         8'h58
`define EV_SPI_ROUT_RESP    8'h59
`define EV_SPI_DEACT        8'h5A
`define EV_SPI_DEACT_RESP   8'h5B
`define EV_PT_EN            8'h60
`define EV_PT_DIS           8'h61
`define EV_PEND_TABLE_WRITE_PRIORITY           8'h62

`endif

/* pmu_event_mux.v */
// selects one event increment amount from the window's event sources by identifier
// assumes sgi and spi event strobes are already security masked upstream; filter qualification is applied here
`timescale 1ns/1ps
`include "pmu_evsel_defs.vh"
module pmu_event_mux (
  // selection
  input  wire [`EVSEL_W-1:0]  eventSel,
  input  wire                 filterHit,
  input  wire                 filterZeroHit,
  // event strobes, one bit each, sgi and spi masked already
  input  wire [3:0]           sgiEv,
  input  wire [6:0]           xlatEv,
  input  wire [5:0]           lpiRemoteEv,
  input  wire [1:0]           storeEv,
  input  wire [6:0]           propEv,
  input  wire [5:0]           spiEv,
  input  wire [4:0]           spiRemoteEv,
  input  wire [1:0]           ptEv,
  // multi-valued amounts
  input  wire [`AMOUNT_W-1:0] xlatLatency,
  input  wire [`AMOUNT_W-1:0] xlatFreeSlots,
  input  wire [`AMOUNT_W-1:0] lpiFreeSlotsNew,
  input  wire                 lpiNew,
  input  wire [`AMOUNT_W-1:0] pendTableWritePriority,
  input  wire                 ptWrite,
  // result
  output reg  [`AMOUNT_W-1:0] incAmount
);

  // one-bit event to amount
  function [`AMOUNT_W-1:0] one;
    input b;
    begin
      one = {{(`AMOUNT_W-1){1'b0}}, b};
    end
  endfunction

  // identifier decode; unlisted ids give zero
  always @* begin
    incAmount = one(1'b0);
    case (eventSel)
      `EV_TGT_SGI_RIN: incAmount = one(sgiEv[0] & filterHit);
      `EV_TGT_SGI_ROUT: incAmount = one(sgiEv[1] & filterHit);
      `EV_ANY_SGI_ROUT: incAmount = one(sgiEv[2] & filterHit);
      `EV_SGI_ROUT_RESP: incAmount = one(sgiEv[3] & filterHit);
      `EV_XLAT_NORMAL: incAmount = one(xlatEv[0] & filterHit);
      `EV_XLAT_LOWLAT: incAmount = one(xlatEv[1] & filterHit);
      `EV_XLAT_ANY: incAmount = one((xlatEv[0] | xlatEv[1]) & filterHit);
      `EV_XLAT_CMD: incAmount = one(xlatEv[2] & filterHit);
      `EV_XLAT_DEVID_MISS: incAmount = one(xlatEv[3] & filterHit);
      `EV_XLAT_EVID_MISS: incAmount = one(xlatEv[4] & filterHit);
      `EV_XLAT_COLL_MISS: incAmount = one(xlatEv[5] & filterHit);
      `EV_XLAT_LATENCY: incAmount = (xlatEv[6] & filterHit) ? xlatLatency : one(1'b0);
      `EV_XLAT_FREE: incAmount = (xlatEv[6] & filterHit) ? xlatFreeSlots : one(1'b0);
      `EV_LPI_ROUT: incAmount = one(lpiRemoteEv[0] & filterHit);
      `EV_LPI_CMD_ROUT: incAmount = one(lpiRemoteEv[1] & filterHit);
      `EV_LPI_RIN: incAmount = one(lpiRemoteEv[2] & filterHit);
      `EV_LPI_CMD_RIN: incAmount = one(lpiRemoteEv[3] & filterHit);
      `EV_LPI_ROUT_RESP: incAmount = one(lpiRemoteEv[4] & filterHit);
      `EV_LPI_CMD_RESP: incAmount = one(lpiRemoteEv[5] & filterHit);
      `EV_STORED_HOME: incAmount = one(storeEv[0]);
      `EV_STORED_ELSE: incAmount = one(storeEv[1]);
      `EV_HIT_EN: incAmount = one(propEv[0] & filterZeroHit);
      `EV_HIT_DIS: incAmount = one(propEv[1] & filterZeroHit);
      `EV_HIT_ANY: incAmount = one((propEv[0] | propEv[1]) & filterZeroHit);
      `EV_COALESCED: incAmount = one(propEv[2] & filterZeroHit);
      `EV_FREE_NEW: incAmount = lpiNew ? lpiFreeSlotsNew : one(1'b0);
      `EV_FETCH_EN: incAmount = one(propEv[3] & filterZeroHit);
      `EV_FETCH_DIS: incAmount = one(propEv[4] & filterZeroHit);
      `EV_FETCH_ANY: incAmount = one((propEv[3] | propEv[4]) & filterZeroHit);
      `EV_COLL_MSG: incAmount = one(spiEv[0] & filterHit);
      `EV_SPI_EN: incAmount = one(spiEv[1] & filterHit);
      `EV_SPI_DIS: incAmount = one(spiEv[2] & filterHit);
      `EV_SPI_PEND_SET: incAmount = one(spiEv[3] & filterHit);
      `EV_SPI_PEND_CLR: incAmount = one(spiEv[4] & filterHit);
      `EV_SPI_COLLATED: incAmount = one(spiEv[5] & filterHit);
      `EV_SPI_RIN: incAmount = one(spiRemoteEv[0] & filterHit);
      `EV_SPI_ROUT: incAmount = one(spiRemoteEv[1] & filterHit);
      `EV_SPI_ROUT_RESP: incAmount = one(spiRemoteEv[2] & filterHit);
      `EV_SPI_DEACT: incAmount = one(spiRemoteEv[3] & filterHit);
      `EV_SPI_DEACT_RESP: incAmount = one(spiRemoteEv[4] & filterHit);
      `EV_PT_EN: incAmount = one(ptEv[0] & filterHit);
      `EV_PT_DIS: incAmount = one(ptEv[1] & filterHit);
      `EV_PEND_TABLE_WRITE_PRIORITY: incAmount = (ptWrite & filterHit) ? pendTableWritePriority : one(1'b0);
      default: incAmount = one(1'b0);
    endcase
  end

endmodule

/* pmu_secure_mask.v */
// security masking of sgi and spi event strobes
// assumes nonsecure flag and group bits arrive in the same cycle as their strobes
`timescale 1ns/1ps
`include "pmu_evsel_defs.vh"
module pmu_secure_mask (
  // control
  input  wire       maskActive,
  // sgi events and their packet flag
  input  wire [3:0] sgiRaw,
  input  wire       nonsecure_flag,
  // spi events and interrupt group
  input  wire [5:0] spiRaw,
  input  wire [4:0] spiRemoteRaw,
  input  wire       spiGroupSecure,
  // masked events
  output wire [3:0] sgiOut,
  output wire [5:0] spiOut,
  output wire [4:0] spiRemoteOut
);

  // drop secure events while masking is active
  assign sgiOut       = sgiRaw & {4{~(maskActive & ~nonsecure_flag)}};
  assign spiOut       = spiRaw & {6{~(maskActive & spiGroupSecure)}};
  assign spiRemoteOut = spiRemoteRaw & {5{~(maskActive & spiGroupSecure)}};

endmodule

/* pmu_event_select_mask.v */
// five event counters with per-counter event selection and security masking
// assumes all event sources and configuration come from logic on ref_clk
`timescale 1ns/1ps
`include "pmu_evsel_defs.vh"
module pmu_event_select_mask (
  // clock and reset
  input  wire                                ref_clk,
  input  wire                                rst_n,
  // configuration
  input  wire [`NUM_COUNTERS*`EVSEL_W-1:0]   event_select_field,
  input  wire [`NUM_COUNTERS-1:0]            counterEnable,
  input  wire [`NUM_COUNTERS-1:0]            filterMatch,
  input  wire                                secure_profiling_restrict,
  input  wire                                security_disable,
  // sgi remote events
  input  wire                                targeted_sgi_remote_in,
  input  wire                                targeted_sgi_remote_out,
  input  wire                                any_sgi_remote_out,
  input  wire                                sgi_remote_out_response,
  input  wire                                nonsecure_flag,
  // translation events
  input  wire                                xlat_normal_lpi_in,
  input  wire                                xlat_lowlat_lpi_in,
  input  wire                                xlat_lpi_command_in,
  input  wire                                xlat_devid_cache_miss,
  input  wire                                xlat_eventid_cache_miss,
  input  wire                                xlat_coll_cache_miss,
  input  wire                                xlat_done,
  input  wire [`AMOUNT_W-1:0]                xlat_transaction_latency,
  input  wire [`AMOUNT_W-1:0]                xlat_free_slots,
  // remote lpi events
  input  wire                                lpi_remote_out,
  input  wire                                lpi_cmd_remote_out,
  input  wire                                lpi_remote_in,
  input  wire                                lpi_cmd_remote_in,
  input  wire                                lpi_remote_out_response,
  input  wire                                lpi_cmd_remote_out_response,
  // lpi storage and property events
  input  wire                                lpi_stored_home,
  input  wire                                lpi_stored_elsewhere,
  input  wire                                fetch_any_a_hit_enabled,
  input  wire                                fetch_any_a_hit_disabled,
  input  wire                                lpi_coalesced,
  input  wire                                fetch_any_a_fetch_enabled,
  input  wire                                fetch_any_a_fetch_disabled,
  input  wire                                lpiNew,
  input  wire [`AMOUNT_W-1:0]                lpi_free_slots_new,
  // spi events
  input  wire                                shared_collator_message,
  input  wire                                spiEnabledEvent,
  input  wire                                spiDisabledEvent,
  input  wire                                spiPendSet,
  input  wire                                shared_irq_pend_clear,
  input  wire                                spiCollatedEdge,
  input  wire                                shared_irq_remote_in,
  input  wire                                shared_irq_remote_out,
  input  wire                                shared_irq_remote_out_resp,
  input  wire                                shared_irq_deact_sent,
  input  wire                                shared_irq_deact_resp,
  input  wire                                spiGroupSecure,
  // pending table events
  input  wire                                pend_table_write_enabled,
  input  wire                                pend_table_write_disabled,
  input  wire [`AMOUNT_W-1:0]                pend_table_write_priority,
  // results
  output wire [`NUM_COUNTERS*`COUNT_W-1:0]   counterValue,
  output wire                                clockKeepAlive,
  output wire                                lowPowerGateBlock
);

  wire                         maskActive;
  wire [3:0]                   sgiMasked;
  wire [5:0]                   spiMasked;
  wire [4:0]                   spiRemoteMasked;
  wire [6:0]                   xlatEv;
  wire [5:0]                   lpiRemoteEv;
  wire [1:0]                   storeEv;
  wire [6:0]                   propEv;
  wire [1:0]                   ptEv;
  wire                         ptWrite;
  wire [`NUM_COUNTERS-1:0]     storeSelected;
  wire [`NUM_COUNTERS*`AMOUNT_W-1:0] incFlat;
  reg  [`COUNT_W-1:0]          count_q [0:`NUM_COUNTERS-1];
  reg  [`COUNT_W-1:0]          count_d [0:`NUM_COUNTERS-1];
  integer                      i;
  integer                      j;
  genvar                       g;

  // storage event test, used per counter
  function isStoreEvent;
    input [`EVSEL_W-1:0] sel;
    begin
      isStoreEvent = (sel == `EV_STORED_HOME) || (sel == `EV_STORED_ELSE);
    end
  endfunction

  // masking applies only with restriction on and security enabled
  assign maskActive = secure_profiling_restrict & ~security_disable;

  // security masking of sgi and spi strobes
  pmu_secure_mask uMask (
    .maskActive     (maskActive),
    .sgiRaw         ({sgi_remote_out_response, any_sgi_remote_out,
                      targeted_sgi_remote_out, targeted_sgi_remote_in}),
    .nonsecure_flag (nonsecure_flag),
    .spiRaw         ({spiCollatedEdge, shared_irq_pend_clear, spiPendSet,
                      spiDisabledEvent, spiEnabledEvent, shared_collator_message}),
    .spiRemoteRaw   ({shared_irq_deact_resp, shared_irq_deact_sent, shared_irq_remote_out_resp,
                      shared_irq_remote_out, shared_irq_remote_in}),
    .spiGroupSecure (spiGroupSecure),
    .sgiOut         (sgiMasked),
    .spiOut         (spiMasked),
    .spiRemoteOut   (spiRemoteMasked)
  );

  // gather unmasked event groups
  assign xlatEv      = {xlat_done, xlat_coll_cache_miss, xlat_eventid_cache_miss, xlat_devid_cache_miss,
                        xlat_lpi_command_in, xlat_lowlat_lpi_in, xlat_normal_lpi_in};
  assign lpiRemoteEv = {lpi_cmd_remote_out_response, lpi_remote_out_response, lpi_cmd_remote_in,
                        lpi_remote_in, lpi_cmd_remote_out, lpi_remote_out};
  assign storeEv     = {lpi_stored_elsewhere, lpi_stored_home};
  assign propEv      = {1'b0, fetch_any_a_fetch_disabled, fetch_any_a_fetch_enabled, lpi_coalesced,
                        fetch_any_a_hit_disabled, fetch_any_a_hit_enabled};
  assign ptEv        = {pend_table_write_disabled, pend_table_write_enabled};
  assign ptWrite     = pend_table_write_enabled | pend_table_write_disabled;

  // one selector per counter, counters 0 to 4
  generate
    for (g = 0; g < `NUM_COUNTERS; g = g + 1) begin : gSel
      pmu_event_mux uMux (
        .eventSel               (event_select_field[g*`EVSEL_W +: `EVSEL_W]),
        .filterHit              (filterMatch[g]),
        .filterZeroHit          (filterMatch[0]),
        .sgiEv                  (sgiMasked),
        .xlatEv                 (xlatEv),
        .lpiRemoteEv            (lpiRemoteEv),
        .storeEv                (storeEv),
        .propEv                 (propEv),
        .spiEv                  (spiMasked),
        .spiRemoteEv            (spiRemoteMasked),
        .ptEv                   (ptEv),
        .xlatLatency            (xlat_transaction_latency),
        .xlatFreeSlots          (xlat_free_slots),
        .lpiFreeSlotsNew        (lpi_free_slots_new),
        .lpiNew                 (lpiNew),
        .pendTableWritePriority (pend_table_write_priority),
        .ptWrite                (ptWrite),
        .incAmount              (incFlat[g*`AMOUNT_W +: `AMOUNT_W])
      );
      assign storeSelected[g] = counterEnable[g] & isStoreEvent(event_select_field[g*`EVSEL_W +: `EVSEL_W]);
      assign counterValue[g*`COUNT_W +: `COUNT_W] = count_q[g];
    end
  endgenerate

  // keep clock alive while any enabled counter watches lpi storage
  assign clockKeepAlive    = |storeSelected;
  assign lowPowerGateBlock = |storeSelected;

  // next counts: enabled counters add their selected amount
  always @* begin
    for (i = 0; i < `NUM_COUNTERS; i = i + 1) begin
      count_d[i] = count_q[i];
      if (counterEnable[i]) begin
        count_d[i] = count_q[i] + {{(`COUNT_W-`AMOUNT_W){1'b0}}, incFlat[i*`AMOUNT_W +: `AMOUNT_W]};
      end
    end
  end

  // counter registers
  always @(posedge ref_clk) begin
    for (j = 0; j < `NUM_COUNTERS; j = j + 1) begin
      if (!rst_n) begin
        count_q[j] <= `COUNTER_RESET;
      end else begin
        count_q[j] <= count_d[j];
      end
    end
  end

endmodule

/* pmu_evsel_checker.sv */
// assertion checker for the event select block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`include "pmu_evsel_defs.vh"
module pmu_evsel_checker (
  // clock and reset
  input wire logic                              ref_clk,
  input wire logic                              rst_n,
  // configuration
  input wire logic [`NUM_COUNTERS*`EVSEL_W-1:0] event_select_field,
  input wire logic [`NUM_COUNTERS-1:0]          counterEnable,
  input wire logic [`NUM_COUNTERS-1:0]          filterMatch,
  input wire logic                              secure_profiling_restrict,
  input wire logic                              security_disable,
  // qualifiers and sample events
  input wire logic                              nonsecure_flag,
  input wire logic                              spiGroupSecure,
  input wire logic                              xlat_normal_lpi_in,
  input wire logic                              lpi_stored_home,
  input wire logic                              fetch_any_a_hit_enabled,
  input wire logic                              fetch_any_a_hit_disabled,
  input wire logic                              lpiNew,
  input wire logic [`AMOUNT_W-1:0]              lpi_free_slots_new,
  // results
  input wire logic [`NUM_COUNTERS*`COUNT_W-1:0] counterValue,
  input wire logic                              clockKeepAlive,
  input wire logic                              lowPowerGateBlock
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  reg  [`NUM_COUNTERS*`COUNT_W-1:0] prevQ;
  reg  [4:0]                        moved, resv, sgiSel, spiSel, keep;
  reg  [7:0]                        s;
  integer                           n;
  wire                              maskOn = secure_profiling_restrict && !security_disable;
  wire [31:0]                       cnt0 = counterValue[31:0];
  wire [31:0]                       cnt1 = counterValue[63:32];
  wire [31:0]                       cnt2 = counterValue[95:64];
  // previous counts for move detection
  always @(posedge ref_clk) prevQ <= counterValue;
  // per-counter classification of the selected identifier
  always @* begin
    for (n = 0; n < 5; n = n + 1) begin
      s = event_select_field[8*n +: 8];
      moved[n] = counterValue[32*n +: 32] != prevQ[32*n +: 32];
      resv[n] = !(s inside {[8'h15:8'h18], [8'h20:8'h2E], [8'h30:8'h39], [8'h50:8'h55], [8'h57:8'h5B], [8'h60:8'h62]});
      sgiSel[n] = s inside {[8'h15:8'h18]};
      spiSel[n] = s inside {[8'h50:8'h5B]};
      keep[n] = counterEnable[n] && (s == 8'h30 || s == 8'h31);
    end
  end
  // single-step causes
  sequence sNormalHit;
    counterEnable[0] && event_select_field[7:0] == 8'h20 && filterMatch[0] && xlat_normal_lpi_in;
  endsequence
  sequence sStoreHome;
    counterEnable[0] && event_select_field[7:0] == 8'h30 && !filterMatch[0] && lpi_stored_home;
  endsequence
  sequence sFreshSlots;
    counterEnable[1] && event_select_field[15:8] == 8'h36 && lpiNew;
  endsequence
  sequence sHitShared;
    counterEnable[2] && event_select_field[23:16] == 8'h34 && filterMatch[0] && (fetch_any_a_hit_enabled || fetch_any_a_hit_disabled);
  endsequence
  AST_KEEPALIVE: assert property ((clockKeepAlive == |keep) && (lowPowerGateBlock == |keep))
    else $error("keepalive outputs disagree with storage event selection");
  AST_RESET_ZERO: assert property ($rose(rst_n) |-> counterValue == '0)
    else $error("counts not zero after reset");
  AST_DISABLED_HOLD: assert property (counterEnable != 5'h1F |=> (moved & ~$past(counterEnable)) == 5'h00)
    else $error("disabled counter moved");
  AST_RESERVED: assert property (resv != 5'h00 |=> (moved & $past(resv)) == 5'h00)
    else $error("counter on reserved identifier moved");
  AST_SGI_MASK: assert property (maskOn && !nonsecure_flag && sgiSel != 5'h00 |=> (moved & $past(sgiSel)) == 5'h00)
    else $error("masked sgi event counted");
  AST_SPI_MASK: assert property (maskOn && spiGroupSecure && spiSel != 5'h00 |=> (moved & $past(spiSel)) == 5'h00)
    else $error("masked spi event counted");
  AST_NORMAL_ONE: assert property (sNormalHit |=> cnt0 - $past(cnt0) == 32'h0000_0001)
    else $error("normal lpi not counted once");
  AST_STORE_UNFILT: assert property (sStoreHome |=> moved[0])
    else $error("storage event blocked by filter");
  AST_FRESH_SLOTS: assert property (sFreshSlots |=> cnt1 - $past(cnt1) == {24'h00_0000, $past(lpi_free_slots_new)})
    else $error("free slot amount not added");
  AST_HIT_SHARED: assert property (sHitShared |=> cnt2 - $past(cnt2) == 32'h0000_0001)
    else $error("property hit not counted under filter zero");
endmodule

/* irq_event_source.sv */
// far-side model: strobes and amounts of the distribution and translation logic
// assumes the block samples everything on the rising edge after it changes
`timescale 1ns/1ps
module irq_event_source (
  // clock and control
  input  wire        ref_clk,
  input  wire        go,
  // strobes and qualifiers
  output reg  [37:0] evStrobe,
  output reg         nsFlag,
  output reg         grpSecure,
  // latency, free, new free, priority amounts
  output reg  [31:0] amounts
);
  integer    seed = 72;
  reg [63:0] r;
  // one-cycle pulses just after each edge; silent while stopped
  always @(posedge ref_clk) begin
    #1;
    r = {$random(seed), $random(seed)};
    evStrobe = go ? r[37:0] : 38'h00_0000_0000;
    nsFlag = r[40];
    grpSecure = r[41];
    amounts = r[63:32];
  end
endmodule

/* tb.sv */
// self-checking bench with a reference count model
// assumes the source model and checker are compiled before it
`timescale 1ns/1ps
`include "pmu_evsel_defs.vh"
module tb;
  reg          ref_clk, rst_n, go, profRestrict, secDisable;
  reg  [39:0]  selField;
  reg  [4:0]   counterEnable, filterMatch;
  wire [37:0]  ev;
  wire         nsFlag, grpSecure, clockKeepAlive, lowPowerGateBlock;
  wire [31:0]  amounts;
  wire [159:0] counterValue;
  reg  [31:0]  expCnt [0:4];
  integer      n_mismatch = 0, total_checks = 0, cyc = 0, seed = 72, id, k;
  irq_event_source src (.ref_clk(ref_clk), .go(go), .evStrobe(ev), .nsFlag(nsFlag), .grpSecure(grpSecure), .amounts(amounts));
  pmu_event_select_mask DUT (.ref_clk(ref_clk), .rst_n(rst_n), .event_select_field(selField),
    .counterEnable(counterEnable), .filterMatch(filterMatch), .secure_profiling_restrict(profRestrict),
    .security_disable(secDisable), .targeted_sgi_remote_in(ev[0]), .targeted_sgi_remote_out(ev[1]),
    .any_sgi_remote_out(ev[2]), .sgi_remote_out_response(ev[3]), .nonsecure_flag(nsFlag),
    .xlat_normal_lpi_in(ev[4]), .xlat_lowlat_lpi_in(ev[5]), .xlat_lpi_command_in(ev[6]),
    .xlat_devid_cache_miss(ev[7]), .xlat_eventid_cache_miss(ev[8]), .xlat_coll_cache_miss(ev[9]),
    .xlat_done(ev[10]), .xlat_transaction_latency(amounts[7:0]), .xlat_free_slots(amounts[15:8]),
    .lpi_remote_out(ev[11]), .lpi_cmd_remote_out(ev[12]), .lpi_remote_in(ev[13]), .lpi_cmd_remote_in(ev[14]),
    .lpi_remote_out_response(ev[15]), .lpi_cmd_remote_out_response(ev[16]), .lpi_stored_home(ev[17]),
    .lpi_stored_elsewhere(ev[18]), .fetch_any_a_hit_enabled(ev[19]), .fetch_any_a_hit_disabled(ev[20]),
    .lpi_coalesced(ev[21]), .fetch_any_a_fetch_enabled(ev[22]), .fetch_any_a_fetch_disabled(ev[23]), .lpiNew(ev[24]),
    .lpi_free_slots_new(amounts[23:16]), .shared_collator_message(ev[25]), .spiEnabledEvent(ev[26]),
    .spiDisabledEvent(ev[27]), .spiPendSet(ev[28]), .shared_irq_pend_clear(ev[29]), .spiCollatedEdge(ev[30]),
    .shared_irq_remote_in(ev[31]), .shared_irq_remote_out(ev[32]), .shared_irq_remote_out_resp(ev[33]),
    .shared_irq_deact_sent(ev[34]), .shared_irq_deact_resp(ev[35]), .spiGroupSecure(grpSecure),
    .pend_table_write_enabled(ev[36]), .pend_table_write_disabled(ev[37]),
    .pend_table_write_priority(amounts[31:24]), .counterValue(counterValue),
    .clockKeepAlive(clockKeepAlive), .lowPowerGateBlock(lowPowerGateBlock));
  // clock and cycle ceiling
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected hang at %0t", $time);
      print_verdict;
    end
  end
  // reference amount added to counter n at this edge
  function automatic [7:0] amt(input integer n);
    integer s, b;
    reg     f, m;
    s = selField[8*n +: 8];
    f = (s >= 'h32 && s <= 'h39) ? filterMatch[0] : filterMatch[n];
    m = (s <= 'h18 && !nsFlag) || (s >= 'h50 && s <= 'h5B && grpSecure);
    b = -1;
    if (s inside {['h15:'h18]}) b = s - 'h15;
    if (s inside {['h20:'h21]}) b = s - 'h1C;
    if (s inside {['h23:'h26]}) b = s - 'h1D;
    if (s inside {['h29:'h2E]}) b = s - 'h1E;
    if (s inside {['h30:'h33]}) b = s - 'h1F;
    if (s inside {['h37:'h38]}) b = s - 'h21;
    if (s inside {['h50:'h55]}) b = s - 'h37;
    if (s inside {['h57:'h5B]}) b = s - 'h38;
    if (s inside {['h60:'h61]}) b = s - 'h3C;
    if (s == 'h35) b = 21;
    if (s == 'h30 || s == 'h31 || s == 'h36) f = 1'b1;
    if (m && profRestrict && !secDisable) f = 1'b0;
    if (!f) return 8'h00;
    if (b >= 0) return {7'h00, ev[b]};
    case (s)
      'h22: return {7'h00, ev[4] | ev[5]};
      'h34: return {7'h00, ev[19] | ev[20]};
      'h39: return {7'h00, ev[22] | ev[23]};
      'h27: return ev[10] ? amounts[7:0] : 8'h00;
      'h28: return ev[10] ? amounts[15:8] : 8'h00;
      'h36: return ev[24] ? amounts[23:16] : 8'h00;
      'h62: return (ev[36] | ev[37]) ? amounts[31:24] : 8'h00;
      default: return 8'h00;
    endcase
  endfunction
  task automatic check_count(input integer n, input [31:0] expV);
    total_checks = total_checks + 1;
    if (counterValue[32*n +: 32] !== expV) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected count at %0t: counter %0d got %h want %h", $time, n, counterValue[32*n +: 32], expV);
    end
  endtask
  task automatic check_bit(input logic got, input logic expV);
    total_checks = total_checks + 1;
    if (got !== expV) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected keepalive at %0t: got %b want %b", $time, got, expV);
    end
  endtask
  // run against the model; rstOdds>0 drops reset at random
  task automatic run_cycles(input integer cnt, input integer rstOdds);
    integer c, n;
    reg     keep;
    for (c = 0; c < cnt; c = c + 1) begin
      @(posedge ref_clk);
      keep = 1'b0;
      for (n = 0; n < 5; n = n + 1) begin
        expCnt[n] = !rst_n ? 32'h0000_0000 : expCnt[n] + (counterEnable[n] ? amt(n) : 8'h00);
        keep = keep | (counterEnable[n] && selField[8*n+1 +: 7] == 7'h18);
      end
      #1;
      for (n = 0; n < 5; n = n + 1) check_count(n, expCnt[n]);
      check_bit(clockKeepAlive, keep);
      check_bit(lowPowerGateBlock, keep);
      filterMatch = $random(seed);
      rst_n = (rstOdds == 0) || ($random(seed) % rstOdds != 0);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // reset, id sweep, random selections with resets
  initial begin
    rst_n = 1'b0;
    go = 1'b0;
    profRestrict = 1'b0;
    secDisable = 1'b0;
    selField = 40'h00_0000_0000;
    counterEnable = 5'h00;
    filterMatch = 5'h00;
    for (k = 0; k < 5; k = k + 1) expCnt[k] = 32'h0000_0000;
    repeat (5) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    go = 1'b1;
    for (id = 'h10; id <= 'h67; id = id + 1) begin
      for (k = 0; k < 5; k = k + 1) selField[8*k +: 8] = id + k;
      counterEnable = $random(seed) | $random(seed);
      profRestrict = $random(seed);
      secDisable = $random(seed);
      run_cycles(6, 0);
    end
    $display("test identifier sweep done");
    for (id = 0; id < 40; id = id + 1) begin
      selField = {$random(seed), $random(seed)};
      counterEnable = $random(seed);
      profRestrict = $random(seed);
      secDisable = $random(seed);
      run_cycles(8, 16);
    end
    $display("test random selection with resets done");
    print_verdict;
  end
endmodule
bind pmu_event_select_mask pmu_evsel_checker u_chk (.*);
